// File: timer_params.svh
// constants for the timer channel block: map, fields, reset values, counts
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define NUM_CH 2
// byte addresses of the registers, one aligned word each
`define ADDR_TSC 12'h000
`define ADDR_CNT_HI 12'h004
`define ADDR_CNT_LO 12'h008
`define ADDR_MOD_HI 12'h00c
`define ADDR_MOD_LO 12'h010
`define ADDR_CH_BASE 12'h020
`define CH_STRIDE 12'h010
`define CH_CSC_OFS 12'h000
`define CH_VH_OFS 12'h004
`define CH_VL_OFS 12'h008
// timer status/control fields
`define WRAP_FLAG_BIT 7
`define WRAP_IE_BIT 6
`define CENTER_BIT 5
`define CLKSEL_HI_BIT 4
`define CLKSEL_LO_BIT 3
// channel status/control fields
`define CH_FLAG_BIT 7
`define CH_IE_BIT 6
`define MODE_HI_BIT 5
`define MODE_LO_BIT 4
`define EDGE_HI_BIT 3
`define EDGE_LO_BIT 2
// counter clock source codes
`define CLK_OFF 2'b00
`define CLK_BUS 2'b01
`define CLK_FIXED 2'b10
`define CLK_EXT 2'b11
// reset values and count points
`define CLKSEL_RESET 2'b00
`define MOD_RESET 16'h0000
`define VALUE_RESET 16'h0000
`define FREE_RUN_TERM 16'hffff
`define FREE_RUN_LOAD 16'hfffe
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001

`endif

// File: timer_pkg.sv
// types shared by the timer channel block
`include "timer_params.svh"
package timer_pkg;

  typedef enum logic [1:0] {mode_capture, mode_compare, mode_edge_pwm, mode_center_pwm} chan_mode_type;

  typedef struct packed {
    logic flag;
    logic flag_armed;
    logic irq_en;
    logic mode_hi;
    logic mode_lo;
    logic edge_hi;
    logic edge_lo;
    logic [15:0] value;
    logic [15:0] wr_buf;
    logic wr_hi_done;
    logic wr_lo_done;
    logic [7:0] rd_buf;
    logic rd_latched;
    logic rd_buf_is_hi;
    logic pin_prev;
    logic pin_level;
    logic pin_drive;
    logic irq;
  } chan_state_type;

  typedef struct packed {
    logic wrap_flag;
    logic wrap_armed;
    logic wrap_irq_en;
    logic center;
    logic [1:0] clk_sel;
    logic [15:0] counter;
    logic [15:0] modulus;
    logic count_down;
    logic ext_prev;
    logic wrap_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    chan_state_type [`NUM_CH-1:0] ch;
  } timer_state_type;

endpackage : timer_pkg

// File: timer_channels.sv
// timer counter with capture, compare and pwm channels behind an apb slave
// What this block does
// [RQ1] with center select clear, two mode bits pick capture, compare or edge pwm
// [RQ2] capture copies counter to channel value on chosen edge; value bytes read-only
// [RQ3] reading one value byte buffers the other; status/control write resets this
// [RQ4] each capture sets the channel flag; enabled flag raises the interrupt
// [RQ5] capture keeps working in debug halt, storing the frozen counter
// [RQ6] compare match sets, clears or toggles the pin per edge/level bits
// [RQ7] compare value writes buffered; load at next counter step after both bytes
// [RQ8] every compare match sets the channel flag, optional interrupt
// [RQ9] edge pwm counts up beside other modes; period modulus plus one
// [RQ10] edge pwm: wrap drives active level, match drives it back; polarity inverts
// [RQ11] edge pwm value zero gives 0%, value above modulus gives 100%
// [RQ12] pwm buffer loads on second write if clock off, else at modulus-1 step
// [RQ13] center pwm counts up to modulus then down to zero
// [RQ14] software keeps modulus 0x0001 to 0x7fff in center mode, never zero
// [RQ15] center pwm value zero or bit 15 set gives 0%, above modulus 100%
// [RQ16] center pwm: up match clears, down match sets; polarity reverses
// [RQ17] software puts every active channel in center pwm when center select set
// [RQ18] in center mode wrap flag sets leaving the count equal to modulus
// [RQ19] reset clears timer control, stops clock, all channels capture, pins free
// [RQ20] wrap flag sets on each terminal count, at the step to the next value
// [RQ21] compare/pwm flag sets on each match; local enables; irqs active high
// [RQ22] flag clears by read seeing it set then writing zero; new event wins
// [RQ23] outside center mode count up from zero to terminal, then wrap to zero
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_channels
  import timer_pkg::*;
(
  input wire logic pclk, // bus clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data, low byte used
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic background_debug_halt, // cpu halted in debug
  input wire logic fixed_clock_tick, // one-cycle tick of fixed clock source
  input wire logic external_clock, // external counter clock level
  input wire logic [`NUM_CH-1:0] channel_pin_in, // channel pin levels
  output logic [`NUM_CH-1:0] channel_pin_out, // channel pin drive levels
  output logic [`NUM_CH-1:0] channel_pin_oe_n, // low while driving the pin
  output logic counter_wrap_irq, // counter wrap interrupt, active high
  output logic [`NUM_CH-1:0] channel_event_irq // channel interrupts, active high
);

  timer_state_type s;
  timer_state_type next_s;

  // helper terms, also watched by the checks
  logic tick;
  logic wrap_now;
  logic step_up;
  logic load_point;
  logic [15:0] next_count;
  logic [15:0] terminal;
  logic setup;
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic hit;
  logic [`NUM_CH-1:0] cap_ev;
  logic [`NUM_CH-1:0] match_ev;
  logic [`NUM_CH-1:0] flag_clr_wr;
  chan_mode_type mode [`NUM_CH];

  // address of one register of channel i
  function automatic logic [11:0] ch_addr(input int i, input logic [11:0] ofs);
    ch_addr = `ADDR_CH_BASE + `CH_STRIDE * i[11:0] + ofs;
  endfunction : ch_addr

  // next state of the whole block
  always_comb begin
    next_s = s;
    setup = psel & ~penable;
    access = psel & penable & s.pready;
    wr = access & pwrite;
    wbyte = pwdata[7:0];
    rbyte = 8'h00;
    hit = 1'b0;
    cap_ev = '0;
    match_ev = '0;
    flag_clr_wr = '0;
    next_s.ext_prev = external_clock;
    // counter step source, frozen while halted
    unique case (s.clk_sel)
      `CLK_OFF: tick = 1'b0;
      `CLK_BUS: tick = 1'b1;
      `CLK_FIXED: tick = fixed_clock_tick;
      `CLK_EXT: tick = external_clock & ~s.ext_prev;
    endcase
    tick = tick & ~background_debug_halt;
    terminal = (s.modulus == `COUNT_ZERO) ? `FREE_RUN_TERM : s.modulus;
    load_point = tick && (s.counter == ((s.modulus == `COUNT_ZERO) ? `FREE_RUN_LOAD
                                        : s.modulus - `COUNT_ONE)); // [RQ12]
    // counter step: up/down in center mode, else up to terminal and wrap
    wrap_now = 1'b0;
    if (s.center) begin
      if (!s.count_down) begin
        if (s.counter == s.modulus) begin
          next_count = s.counter - `COUNT_ONE; // [RQ13]
          wrap_now = 1'b1; // [RQ18]
        end else begin
          next_count = s.counter + `COUNT_ONE;
        end
      end else if (s.counter == `COUNT_ZERO) begin
        next_count = s.counter + `COUNT_ONE; // [RQ13]
      end else begin
        next_count = s.counter - `COUNT_ONE;
      end
    end else if (s.counter == terminal) begin
      next_count = `COUNT_ZERO; // [RQ23]
      wrap_now = 1'b1; // [RQ20]
    end else begin
      next_count = s.counter + `COUNT_ONE; // [RQ9]
    end
    step_up = next_count > s.counter;
    if (tick) begin
      next_s.counter = next_count;
      next_s.count_down = s.center & ~step_up;
    end
    // read decode of the shared registers
    unique case (paddr)
      `ADDR_TSC: begin
        hit = 1'b1;
        rbyte = {s.wrap_flag, s.wrap_irq_en, s.center, s.clk_sel, 3'b000};
      end
      `ADDR_CNT_HI: begin
        hit = 1'b1;
        rbyte = s.counter[15:8];
      end
      `ADDR_CNT_LO: begin
        hit = 1'b1;
        rbyte = s.counter[7:0];
      end
      `ADDR_MOD_HI: begin
        hit = 1'b1;
        rbyte = s.modulus[15:8];
      end
      `ADDR_MOD_LO: begin
        hit = 1'b1;
        rbyte = s.modulus[7:0];
      end
      default: ;
    endcase
    // wrap flag: read seeing it set arms, write of zero then clears
    if (setup && !pwrite && paddr == `ADDR_TSC && s.wrap_flag) begin
      next_s.wrap_armed = 1'b1; // [RQ22]
    end
    if (wr && paddr == `ADDR_TSC) begin
      next_s.wrap_irq_en = wbyte[`WRAP_IE_BIT];
      next_s.center = wbyte[`CENTER_BIT];
      next_s.clk_sel = wbyte[`CLKSEL_HI_BIT:`CLKSEL_LO_BIT];
      next_s.wrap_armed = 1'b0;
      if (s.wrap_armed && !wbyte[`WRAP_FLAG_BIT]) begin
        next_s.wrap_flag = 1'b0; // [RQ22]
      end
    end
    if (tick && wrap_now) begin
      next_s.wrap_flag = 1'b1; // set wins over clear [RQ20] [RQ22]
      next_s.wrap_armed = 1'b0;
    end
    next_s.wrap_irq = next_s.wrap_flag & next_s.wrap_irq_en;
    // any counter byte write restarts the count
    if (wr && (paddr == `ADDR_CNT_HI || paddr == `ADDR_CNT_LO)) begin
      next_s.counter = `COUNT_ZERO;
      next_s.count_down = 1'b0;
    end
    if (wr && paddr == `ADDR_MOD_HI) begin
      next_s.modulus[15:8] = wbyte;
    end
    if (wr && paddr == `ADDR_MOD_LO) begin
      next_s.modulus[7:0] = wbyte;
    end
    // per-channel logic
    for (int i = 0; i < `NUM_CH; i++) begin
      // mode from center select and the two mode bits [RQ1]
      if (s.center) begin
        mode[i] = mode_center_pwm;
      end else if (s.ch[i].mode_hi) begin
        mode[i] = mode_edge_pwm;
      end else if (s.ch[i].mode_lo) begin
        mode[i] = mode_compare;
      end else begin
        mode[i] = mode_capture;
      end
      next_s.ch[i].pin_prev = channel_pin_in[i];
      // selected active edge: rising, falling or either
      cap_ev[i] = (mode[i] == mode_capture) &&
                  ((s.ch[i].edge_lo & channel_pin_in[i] & ~s.ch[i].pin_prev) |
                   (s.ch[i].edge_hi & ~channel_pin_in[i] & s.ch[i].pin_prev)); // [RQ2] [RQ5]
      match_ev[i] = (mode[i] != mode_capture) && tick && next_count == s.ch[i].value; // [RQ21]
      // buffered value load point depends on clock and mode
      if (s.ch[i].wr_hi_done && s.ch[i].wr_lo_done && !background_debug_halt &&
          (s.clk_sel == `CLK_OFF ||
           (mode[i] == mode_compare && tick) ||
           (mode[i] != mode_compare && mode[i] != mode_capture && load_point))) begin
        next_s.ch[i].value = s.ch[i].wr_buf; // [RQ7] [RQ12]
        next_s.ch[i].wr_hi_done = 1'b0;
        next_s.ch[i].wr_lo_done = 1'b0;
      end
      // register reads
      if (paddr == ch_addr(i, `CH_CSC_OFS)) begin
        hit = 1'b1;
        rbyte = {s.ch[i].flag, s.ch[i].irq_en, s.ch[i].mode_hi, s.ch[i].mode_lo,
                 s.ch[i].edge_hi, s.ch[i].edge_lo, 2'b00};
        if (setup && !pwrite && s.ch[i].flag) begin
          next_s.ch[i].flag_armed = 1'b1; // [RQ22]
        end
      end
      if (paddr == ch_addr(i, `CH_VH_OFS)) begin
        hit = 1'b1;
        if (!background_debug_halt && s.ch[i].rd_latched && s.ch[i].rd_buf_is_hi) begin
          rbyte = s.ch[i].rd_buf;
          if (setup && !pwrite) next_s.ch[i].rd_latched = 1'b0; // [RQ3]
        end else begin
          rbyte = s.ch[i].value[15:8];
          if (setup && !pwrite && !background_debug_halt) begin
            next_s.ch[i].rd_buf = s.ch[i].value[7:0]; // [RQ3]
            next_s.ch[i].rd_latched = 1'b1;
            next_s.ch[i].rd_buf_is_hi = 1'b0;
          end
        end
      end
      if (paddr == ch_addr(i, `CH_VL_OFS)) begin
        hit = 1'b1;
        if (!background_debug_halt && s.ch[i].rd_latched && !s.ch[i].rd_buf_is_hi) begin
          rbyte = s.ch[i].rd_buf;
          if (setup && !pwrite) next_s.ch[i].rd_latched = 1'b0; // [RQ3]
        end else begin
          rbyte = s.ch[i].value[7:0];
          if (setup && !pwrite && !background_debug_halt) begin
            next_s.ch[i].rd_buf = s.ch[i].value[15:8]; // [RQ3]
            next_s.ch[i].rd_latched = 1'b1;
            next_s.ch[i].rd_buf_is_hi = 1'b1;
          end
        end
      end
      // status/control write: controls, flag clear, sequences restart
      if (wr && paddr == ch_addr(i, `CH_CSC_OFS)) begin
        next_s.ch[i].irq_en = wbyte[`CH_IE_BIT];
        next_s.ch[i].mode_hi = wbyte[`MODE_HI_BIT];
        next_s.ch[i].mode_lo = wbyte[`MODE_LO_BIT];
        next_s.ch[i].edge_hi = wbyte[`EDGE_HI_BIT];
        next_s.ch[i].edge_lo = wbyte[`EDGE_LO_BIT];
        next_s.ch[i].flag_armed = 1'b0;
        next_s.ch[i].rd_latched = 1'b0; // [RQ3]
        next_s.ch[i].wr_hi_done = 1'b0;
        next_s.ch[i].wr_lo_done = 1'b0;
        flag_clr_wr[i] = s.ch[i].flag_armed && !wbyte[`CH_FLAG_BIT];
        if (flag_clr_wr[i]) next_s.ch[i].flag = 1'b0; // [RQ22]
      end
      // value byte writes: ignored in capture, direct in halt, else buffered
      if (wr && mode[i] != mode_capture &&
          (paddr == ch_addr(i, `CH_VH_OFS) || paddr == ch_addr(i, `CH_VL_OFS))) begin // [RQ2]
        if (background_debug_halt) begin
          if (paddr == ch_addr(i, `CH_VH_OFS)) next_s.ch[i].value[15:8] = wbyte;
          else next_s.ch[i].value[7:0] = wbyte;
        end else if (paddr == ch_addr(i, `CH_VH_OFS)) begin
          next_s.ch[i].wr_buf[15:8] = wbyte; // [RQ7]
          next_s.ch[i].wr_hi_done = 1'b1;
        end else begin
          next_s.ch[i].wr_buf[7:0] = wbyte; // [RQ7]
          next_s.ch[i].wr_lo_done = 1'b1;
        end
      end
      // capture stores the counter, frozen while halted
      if (cap_ev[i]) begin
        next_s.ch[i].value = s.counter; // [RQ2] [RQ5]
      end
      // pin behaviour per mode
      unique case (mode[i])
        mode_capture: ;
        mode_compare: begin
          if (match_ev[i]) begin
            unique case ({s.ch[i].edge_hi, s.ch[i].edge_lo})
              2'b00: ;
              2'b01: next_s.ch[i].pin_level = ~s.ch[i].pin_level; // [RQ6]
              2'b10: next_s.ch[i].pin_level = 1'b0; // [RQ6]
              2'b11: next_s.ch[i].pin_level = 1'b1; // [RQ6]
            endcase
          end
        end
        mode_edge_pwm: begin
          // match wins over a wrap in the same step, so value zero stays inactive [RQ11]
          if (match_ev[i]) next_s.ch[i].pin_level = s.ch[i].edge_lo; // [RQ10]
          else if (tick && wrap_now) next_s.ch[i].pin_level = ~s.ch[i].edge_lo; // [RQ10]
        end
        mode_center_pwm: begin
          if (s.ch[i].value == `COUNT_ZERO || s.ch[i].value[15]) begin
            next_s.ch[i].pin_level = s.ch[i].edge_lo; // [RQ15]
          end else if (s.ch[i].value > s.modulus && s.modulus != `COUNT_ZERO) begin
            next_s.ch[i].pin_level = ~s.ch[i].edge_lo; // [RQ15]
          end else if (match_ev[i]) begin
            next_s.ch[i].pin_level = step_up ? s.ch[i].edge_lo : ~s.ch[i].edge_lo; // [RQ16]
          end
        end
      endcase
      next_s.ch[i].pin_drive = (mode[i] != mode_capture) && (s.ch[i].edge_hi | s.ch[i].edge_lo);
      // events set the flag, winning over a clear in the same cycle
      if (cap_ev[i] || match_ev[i]) begin
        next_s.ch[i].flag = 1'b1; // [RQ4] [RQ8] [RQ21] [RQ22]
        next_s.ch[i].flag_armed = 1'b0;
      end
      next_s.ch[i].irq = next_s.ch[i].flag & next_s.ch[i].irq_en; // [RQ4] [RQ21]
    end
    // apb answer: ready one cycle after setup, error on unmapped address
    next_s.pready = setup;
    next_s.pslverr = setup & ~hit;
    if (setup) next_s.prdata = (!pwrite && hit) ? {24'h000000, rbyte} : 32'h00000000;
  end

  // state register; reset clears all control [RQ19]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign counter_wrap_irq = s.wrap_irq;
  for (genvar g = 0; g < `NUM_CH; g++) begin : g_pins
    assign channel_pin_out[g] = s.ch[g].pin_level;
    assign channel_pin_oe_n[g] = ~s.ch[g].pin_drive;
    assign channel_event_irq[g] = s.ch[g].irq;
  end

  // checks on the counter and both channels
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wrap_flag_set: assert property (tick && wrap_now |=> s.wrap_flag) // [RQ20]
    else $error("wrap flag not set at terminal count");
  chk_count_wrap_zero: assert property (tick && !s.center && s.counter == terminal && !wr
                                        |=> s.counter == 16'h0000 && s.wrap_flag) // [RQ23]
    else $error("counter did not wrap to zero");
  chk_center_turn: assert property (tick && s.center && !s.count_down && s.counter == s.modulus && !wr
                                    |=> s.count_down && s.counter == $past(s.counter) - 16'h0001) // [RQ18]
    else $error("center count did not turn at modulus");
  chk_capture_value: assert property (cap_ev[0] |=> s.ch[0].value == $past(s.counter) && s.ch[0].flag) // [RQ2]
    else $error("capture did not store counter");
  chk_compare_toggle: assert property (match_ev[1] && mode[1] == mode_compare && !s.ch[1].edge_hi &&
                                       s.ch[1].edge_lo |=> channel_pin_out[1] != $past(channel_pin_out[1])) // [RQ6]
    else $error("compare toggle missing");
  chk_epwm_match_level: assert property (match_ev[0] && mode[0] == mode_edge_pwm
                                         |=> channel_pin_out[0] == $past(s.ch[0].edge_lo)) // [RQ10]
    else $error("edge pwm match level wrong");
  chk_flag_set_wins: assert property ((cap_ev[0] || match_ev[0]) && flag_clr_wr[0] |=> s.ch[0].flag ##1 s.ch[0].flag) // [RQ22]
    else $error("flag lost to clear");
  chk_irq_follows: assert property (s.ch[0].flag && s.ch[0].irq_en |-> channel_event_irq[0]) // [RQ4]
    else $error("channel interrupt not raised");
  // buffered load at the pwm load point, forced level for a negative center value
  chk_pwm_load_point: assert property (s.ch[0].wr_hi_done && s.ch[0].wr_lo_done && load_point && !wr && // [RQ12]
    mode[0] == mode_edge_pwm && !background_debug_halt |=> s.ch[0].value == $past(s.ch[0].wr_buf))
    else $error("pwm buffer not loaded");
  chk_center_zero_duty: assert property (mode[0] == mode_center_pwm && s.ch[0].value[15] // [RQ15]
    |=> channel_pin_out[0] == $past(s.ch[0].edge_lo)) else $error("center zero duty level wrong");
  chk_capture_readonly: assert property (wr && mode[0] == mode_capture && !cap_ev[0] && !background_debug_halt
                                         |=> $stable(s.ch[0].value)) // [RQ2]
    else $error("capture value written by bus");

endmodule : timer_channels

// File: pin_partner.sv
// far side of the channel pins: event sources, pin loads and counter clock sources
`timescale 1ns/1ps
`include "timer_params.svh"
module pin_partner
  import timer_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [`NUM_CH-1:0] src_level, // level the event source puts on each pin
  input wire logic [`NUM_CH-1:0] pin_out, // drive level from the block
  input wire logic [`NUM_CH-1:0] pin_oe_n, // low while the block drives
  output logic [`NUM_CH-1:0] pin_in, // resolved pin level
  output logic external_clock, // free-running, an eighth of pclk
  output logic fixed_clock_tick // one pulse every fourth pclk
);
  logic [2:0] div;
  // event source yields the pin while the block drives it
  assign pin_in = (pin_oe_n & src_level) | (~pin_oe_n & pin_out);
  // divider for the alternative counter clocks, kept at or under a quarter of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end
  assign external_clock = div[2];
  assign fixed_clock_tick = (div[1:0] == 2'h3);
endmodule : pin_partner

// File: timer_channels_tb_top.sv
// self-checking bench for the timer channel block
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_channels_tb_top
  import timer_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, background_debug_halt;
  logic fixed_clock_tick, external_clock, counter_wrap_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [`NUM_CH-1:0] channel_pin_in, channel_pin_out, channel_pin_oe_n, channel_event_irq, src_level;
  logic [7:0] q, hi, lo;
  int error_cnt, n_tests, hn, rn;
  int cv[5], ce[5], eh[5], er[5];

  timer_channels timer_channels_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .background_debug_halt, .fixed_clock_tick, .external_clock, .channel_pin_in,
    .channel_pin_out, .channel_pin_oe_n, .counter_wrap_irq, .channel_event_irq);
  pin_partner pin_partner_i(.pclk, .presetn, .src_level, .pin_out(channel_pin_out),
    .pin_oe_n(channel_pin_oe_n), .pin_in(channel_pin_in), .external_clock, .fixed_clock_tick);

  // verdict and end of run
  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic chk_near(input logic [31:0] g, input int e, input int t, input string m);
    n_tests++;
    if ($isunknown(g) || int'(g) > e + t || int'(g) < e - t) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h near %0d", $time, m, g, e);
    end
  endtask : chk_near

  // one apb transfer: setup, access held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] x,
                      output logic r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "pready");
    x = prdata[7:0];
    r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic r;
    xfer(1'b1, a, d, x, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] x);
    logic r;
    xfer(1'b0, a, 8'h00, x, r);
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input logic [7:0] k, input string m);
    logic [7:0] x;
    rd(a, x);
    chk({24'h0, x & k}, {24'h0, e & k}, m);
  endtask : rd_chk

  function automatic logic [11:0] ca(input int n, input logic [11:0] o);
    return `ADDR_CH_BASE + `CH_STRIDE * 12'(n) + o;
  endfunction : ca

  task automatic setv(input int n, input logic [15:0] v);
    wr(ca(n, `CH_VH_OFS), v[15:8]);
    wr(ca(n, `CH_VL_OFS), v[7:0]);
  endtask : setv

  task automatic wait_irq(input int c);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (channel_event_irq[c] !== 1'b1 && n < 200);
    chk({31'h0, channel_event_irq[c]}, 32'h1, "channel irq");
  endtask : wait_irq

  // count high cycles and rising edges of one pin
  task automatic measure(input int c, input int cyc, output int h, output int r);
    logic p;
    h = 0;
    r = 0;
    @(posedge pclk);
    p = channel_pin_out[c];
    repeat (cyc) begin
      @(posedge pclk);
      if (channel_pin_out[c] === 1'b1) begin
        h++;
        if (p !== 1'b1) r++;
      end
      p = channel_pin_out[c];
    end
  endtask : measure

  // bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, background_debug_halt} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    src_level = 2'h0;
    error_cnt = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({28'h0, channel_pin_oe_n, channel_event_irq}, 32'hc, "reset pins");
    rd_chk(`ADDR_TSC, 8'h00, 8'hff, "reset tsc");
    rd_chk(ca(0, `CH_CSC_OFS), 8'h00, 8'hff, "reset csc0");
    rd_chk(ca(1, `CH_CSC_OFS), 8'h00, 8'hff, "reset csc1");
    xfer(1'b0, 12'h0fc, 8'h00, q, hi[0]);
    chk({23'h0, hi[0], q}, 32'h100, "unmapped");
    // fixed tick and external clock sources
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_CNT_LO, 8'h00);
      wr(`ADDR_TSC, i ? 8'h18 : 8'h10);
      repeat (80) @(posedge pclk);
      wr(`ADDR_TSC, 8'h00);
      rd(`ADDR_CNT_LO, q);
      chk_near({24'h0, q}, i ? 10 : 21, 3, "count rate");
    end
    // capture during debug halt
    wr(ca(0, `CH_CSC_OFS), 8'h44);
    wr(`ADDR_CNT_LO, 8'h00);
    wr(`ADDR_TSC, 8'h08);
    repeat (30) @(posedge pclk);
    background_debug_halt <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`ADDR_CNT_HI, hi);
    rd(`ADDR_CNT_LO, lo);
    src_level[0] <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_chk(ca(0, `CH_VH_OFS), hi, 8'hff, "capture hi");
    rd_chk(ca(0, `CH_VL_OFS), lo, 8'hff, "capture lo");
    rd_chk(ca(0, `CH_CSC_OFS), 8'hc4, 8'hff, "capture flag");
    chk({31'h0, channel_event_irq[0]}, 32'h1, "capture irq");
    wr(ca(0, `CH_CSC_OFS), 8'h44);
    rd_chk(ca(0, `CH_CSC_OFS), 8'h44, 8'hff, "flag clear");
    chk({31'h0, channel_event_irq[0]}, 32'h0, "irq clear");
    background_debug_halt <= 1'b0;
    wr(ca(0, `CH_VH_OFS), 8'haa);
    rd_chk(ca(0, `CH_VH_OFS), hi, 8'hff, "value read-only");
    // coherent capture read across a second capture
    wr(ca(0, `CH_CSC_OFS), 8'h0c);
    wr(`ADDR_CNT_LO, 8'h00);
    repeat (100) @(posedge pclk);
    src_level[0] <= 1'b0;
    repeat (5) @(posedge pclk);
    rd(ca(0, `CH_VL_OFS), lo);
    chk({24'h0, lo}, 32'h64, "first capture lo");
    repeat (300) @(posedge pclk);
    src_level[0] <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_chk(ca(0, `CH_VH_OFS), 8'h00, 8'hff, "buffered hi");
    wr(ca(0, `CH_CSC_OFS), 8'h0c);
    rd_chk(ca(0, `CH_VH_OFS), 8'h01, 8'hff, "live hi");
    // output compare on channel 1: set, clear, toggle
    wr(`ADDR_MOD_HI, 8'h00);
    wr(`ADDR_MOD_LO, 8'h20);
    cv = '{3, 2, 1, 0, 0};
    ce = '{1, 0, 1, 0, 0};
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_TSC, 8'h00);
      wr(ca(1, `CH_CSC_OFS), {4'h5, cv[i][1:0], 2'h0});
      setv(1, 16'h0010);
      wr(`ADDR_CNT_LO, 8'h00);
      wr(`ADDR_TSC, 8'h08);
      wait_irq(1);
      wr(`ADDR_TSC, 8'h00);
      chk({30'h0, channel_pin_out[1], channel_pin_oe_n[1]}, ce[i] * 2, "compare pin");
      rd_chk(ca(1, `CH_CSC_OFS), {4'hd, cv[i][1:0], 2'h0}, 8'hff, "compare flag");
    end
    // new match between flag read and clearing write
    wr(ca(1, `CH_CSC_OFS), 8'h54);
    wr(`ADDR_TSC, 8'h08);
    wait_irq(1);
    rd(ca(1, `CH_CSC_OFS), q);
    repeat (40) @(posedge pclk);
    wr(ca(1, `CH_CSC_OFS), 8'h54);
    rd_chk(ca(1, `CH_CSC_OFS), 8'h80, 8'h80, "flag kept");
    wr(ca(1, `CH_CSC_OFS), 8'h00);
    // edge-aligned pwm, period ten
    wr(`ADDR_MOD_LO, 8'h09);
    cv = '{3, 3, 0, 10, 0};
    ce = '{2, 3, 2, 2, 0};
    eh = '{30, 70, 0, 100, 0};
    er = '{10, 10, 0, 0, 0};
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_TSC, 8'h00);
      wr(ca(0, `CH_CSC_OFS), {4'h2, ce[i][1:0], 2'h0});
      setv(0, 16'(cv[i]));
      wr(`ADDR_CNT_LO, 8'h00);
      wr(`ADDR_TSC, 8'h48);
      repeat (20) @(posedge pclk);
      measure(0, 100, hn, rn);
      chk(hn, eh[i], "edge duty");
      chk(rn, er[i], "edge period");
      chk({31'h0, counter_wrap_irq}, 32'h1, "wrap irq");
      rd_chk(`ADDR_TSC, 8'hc8, 8'hff, "wrap flag");
    end
    setv(0, 16'h0005);
    repeat (30) @(posedge pclk);
    measure(0, 100, hn, rn);
    chk(hn, 50, "running load");
    // center-aligned pwm, modulus eight
    wr(ca(1, `CH_CSC_OFS), 8'h20);
    wr(`ADDR_MOD_LO, 8'h08);
    cv = '{3, 3, 0, 32773, 9};
    ce = '{2, 3, 2, 2, 2};
    eh = '{60, 100, 0, 0, 160};
    er = '{10, 10, 0, 0, 0};
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_TSC, 8'h20);
      wr(ca(0, `CH_CSC_OFS), {4'h2, ce[i][1:0], 2'h0});
      setv(0, 16'(cv[i]));
      wr(`ADDR_CNT_LO, 8'h00);
      wr(`ADDR_TSC, 8'h28);
      repeat (20) @(posedge pclk);
      measure(0, 160, hn, rn);
      chk(hn, eh[i], "center duty");
      chk(rn, er[i], "center period");
      rd_chk(`ADDR_TSC, 8'h80, 8'h80, "center wrap");
    end
    finish_test();
  end
endmodule : timer_channels_tb_top
